// File: rtl/wake_power_mgmt.sv
module wake_power_mgmt
    import wake_pkg::*;
#(
    parameter int nfilt = num_filters
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // receive path, same clock
    input wire rx_beat_t rx_in,
    input wire logic rx_addr_ok,
    // frames passed on to the rest of the mac
    output rx_beat_t rx_out,
    // power state
    output logic low_power_mode,
    output logic wakeup_irq
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic pd_r, pd_nxt;
    logic wake_on_unicast_en_r, wake_on_unicast_en_nxt;
    logic wake_on_filter_match_en_r, wake_on_filter_match_en_nxt;
    logic wake_on_magic_frame_en_r, wake_on_magic_frame_en_nxt;
    logic filter_wake_seen_r, filter_wake_seen_nxt;
    logic magic_wake_seen_r, magic_wake_seen_nxt;
    logic irq_r, irq_nxt;
    logic [47:0] station_r, station_nxt;
    filter_cfg_t [nfilt-1:0] flt_r, flt_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    rx_beat_t rx_out_r, rx_out_nxt;

    // ------------------------------------------------------------
    // frame tracking
    // ------------------------------------------------------------
    logic [7:0] idx_r, idx_nxt;
    logic group_r, group_nxt;
    logic uni_ok_r, uni_ok_nxt;
    logic eof_d_r;
    logic cur_group;
    logic [nfilt-1:0] flt_hit;
    logic magic_hit;

    // byte 0 is the first destination byte; bit 0 of it is the group bit
    assign cur_group = (rx_in.sof) ? rx_in.data[0] : group_r;

    always_comb begin
        idx_nxt = idx_r;
        group_nxt = group_r;
        uni_ok_nxt = uni_ok_r;
        if (rx_in.valid) begin
            if (rx_in.sof) begin
                idx_nxt = 8'd1;
                group_nxt = rx_in.data[0];
                uni_ok_nxt = 1'b0;
            end else if (idx_r != 8'hff) begin
                idx_nxt = idx_r + 8'd1;
            end
            if (rx_in.eof) begin
                uni_ok_nxt = rx_addr_ok && !cur_group;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_r <= '0;
            group_r <= 1'b0;
            uni_ok_r <= 1'b0;
            eof_d_r <= 1'b0;
        end else begin
            idx_r <= idx_nxt;
            group_r <= group_nxt;
            uni_ok_r <= uni_ok_nxt;
            eof_d_r <= rx_in.valid && rx_in.eof;
        end
    end

    // ------------------------------------------------------------
    // wake detectors
    // ------------------------------------------------------------
    // all filters see the frame while awake too; only power-down acts on hits
    for (genvar g = 0; g < nfilt; g++) begin : g_flt
        wake_crc_filter u_flt (
            .pclk(pclk),
            .presetn(presetn),
            .cfg(flt_r[g]),
            .beat(rx_in),
            .byte_idx(rx_in.sof ? 8'd0 : idx_r),
            .dest_group(cur_group),
            .hit(flt_hit[g])
        );
    end

    wake_magic_detect u_magic (
        .pclk(pclk),
        .presetn(presetn),
        .station(station_r),
        .beat(rx_in),
        .found(magic_hit)
    );

    // ------------------------------------------------------------
    // receive gate
    // ------------------------------------------------------------
    always_comb begin
        rx_out_nxt = rx_in;
        if (pd_r) begin
            rx_out_nxt.valid = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // apb access and power state
    // ------------------------------------------------------------
    logic wr_en, rd_en, bad_addr;
    logic wake_filter, wake_magic, wake_uni, wake_any;
    logic [31:0] rd_val;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    always_comb begin
        wake_filter = pd_r && wake_on_filter_match_en_r && (|flt_hit);
        wake_magic = pd_r && wake_on_magic_frame_en_r && magic_hit;
        wake_uni = pd_r && wake_on_unicast_en_r && eof_d_r && uni_ok_r;
        wake_any = wake_filter || wake_magic || wake_uni;
    end

    always_comb begin
        rd_val = '0;
        bad_addr = 1'b0;
        case (paddr)
            ctrl_off: begin
                rd_val[ctrl_pd_bit] = pd_r;
                rd_val[ctrl_magic_bit] = wake_on_magic_frame_en_r;
                rd_val[ctrl_filter_bit] = wake_on_filter_match_en_r;
                rd_val[ctrl_unicast_bit] = wake_on_unicast_en_r;
            end
            status_off: begin
                rd_val[stat_pd_bit] = pd_r;
                rd_val[stat_filter_bit] = filter_wake_seen_r;
                rd_val[stat_magic_bit] = magic_wake_seen_r;
            end
            station_lo_off: rd_val = station_r[31:0];
            station_hi_off: rd_val[15:0] = station_r[47:32];
            flt_cmd_off: begin
                for (int i = 0; i < nfilt; i++) begin
                    rd_val[i*8 + cmd_on_bit] = flt_r[i].on;
                    rd_val[i*8 + cmd_group_bit] = flt_r[i].group_sel;
                end
            end
            flt_offset_off: begin
                for (int i = 0; i < nfilt; i++) begin
                    rd_val[i*8 +: 8] = flt_r[i].start_offset;
                end
            end
            flt_crc01_off: rd_val = {flt_r[1].expected, flt_r[0].expected};
            flt_crc23_off: rd_val = {flt_r[3].expected, flt_r[2].expected};
            default: begin
                if (paddr >= flt_mask_base && paddr < flt_mask_base + 8'(nfilt * 4) && paddr[1:0] == 2'b00) begin
                    rd_val[30:0] = flt_r[paddr[3:2]].byte_mask;
                end else begin
                    bad_addr = 1'b1;
                end
            end
        endcase
    end

    always_comb begin
        pd_nxt = pd_r;
        wake_on_unicast_en_nxt = wake_on_unicast_en_r;
        wake_on_filter_match_en_nxt = wake_on_filter_match_en_r;
        wake_on_magic_frame_en_nxt = wake_on_magic_frame_en_r;
        filter_wake_seen_nxt = filter_wake_seen_r;
        magic_wake_seen_nxt = magic_wake_seen_r;
        irq_nxt = irq_r;
        station_nxt = station_r;
        flt_nxt = flt_r;
        prdata_nxt = prdata_r;
        if (rd_en) begin
            prdata_nxt = rd_val;
            if (paddr == status_off) begin
                filter_wake_seen_nxt = 1'b0;
                magic_wake_seen_nxt = 1'b0;
                irq_nxt = 1'b0;
            end
        end
        if (wr_en && !bad_addr) begin
            case (paddr)
                ctrl_off: begin
                    pd_nxt = pwdata[ctrl_pd_bit];
                    wake_on_magic_frame_en_nxt = pwdata[ctrl_magic_bit];
                    wake_on_filter_match_en_nxt = pwdata[ctrl_filter_bit];
                    wake_on_unicast_en_nxt = pwdata[ctrl_unicast_bit];
                end
                station_lo_off: station_nxt[31:0] = pwdata;
                station_hi_off: station_nxt[47:32] = pwdata[15:0];
                flt_cmd_off: begin
                    for (int i = 0; i < nfilt; i++) begin
                        flt_nxt[i].on = pwdata[i*8 + cmd_on_bit];
                        flt_nxt[i].group_sel = pwdata[i*8 + cmd_group_bit];
                    end
                end
                flt_offset_off: begin
                    for (int i = 0; i < nfilt; i++) begin
                        flt_nxt[i].start_offset = pwdata[i*8 +: 8];
                    end
                end
                flt_crc01_off: begin
                    flt_nxt[0].expected = pwdata[15:0];
                    flt_nxt[1].expected = pwdata[31:16];
                end
                flt_crc23_off: begin
                    flt_nxt[2].expected = pwdata[15:0];
                    flt_nxt[3].expected = pwdata[31:16];
                end
                status_off: begin
                end
                default: flt_nxt[paddr[3:2]].byte_mask = pwdata[30:0];
            endcase
        end
        // hardware wake wins over a same-cycle status read or control write
        if (wake_any) begin
            pd_nxt = 1'b0;
            irq_nxt = 1'b1;
        end
        if (wake_filter) begin
            filter_wake_seen_nxt = 1'b1;
        end
        if (wake_magic) begin
            magic_wake_seen_nxt = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd_r <= 1'b0;
            wake_on_unicast_en_r <= 1'b0;
            wake_on_filter_match_en_r <= 1'b0;
            wake_on_magic_frame_en_r <= 1'b0;
            filter_wake_seen_r <= 1'b0;
            magic_wake_seen_r <= 1'b0;
            irq_r <= 1'b0;
            station_r <= '0;
            flt_r <= '0;
            prdata_r <= '0;
            rx_out_r <= '0;
        end else begin
            pd_r <= pd_nxt;
            wake_on_unicast_en_r <= wake_on_unicast_en_nxt;
            wake_on_filter_match_en_r <= wake_on_filter_match_en_nxt;
            wake_on_magic_frame_en_r <= wake_on_magic_frame_en_nxt;
            filter_wake_seen_r <= filter_wake_seen_nxt;
            magic_wake_seen_r <= magic_wake_seen_nxt;
            irq_r <= irq_nxt;
            station_r <= station_nxt;
            flt_r <= flt_nxt;
            prdata_r <= prdata_nxt;
            rx_out_r <= rx_out_nxt;
        end
    end

    // zero-wait slave: data for a read is taken at the access edge from rd_val
    assign prdata = (rd_en) ? rd_val : prdata_r;
    assign pready = 1'b1;
    assign pslverr = psel && penable && bad_addr;
    assign rx_out = rx_out_r;
    assign low_power_mode = pd_r;
    assign wakeup_irq = irq_r;

endmodule

// File: rtl/wake_pkg.sv
package wake_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] status_off = 8'h04;
    localparam logic [7:0] station_lo_off = 8'h08;
    localparam logic [7:0] station_hi_off = 8'h0c;
    localparam logic [7:0] flt_mask_base = 8'h10;
    localparam logic [7:0] flt_cmd_off = 8'h20;
    localparam logic [7:0] flt_offset_off = 8'h24;
    localparam logic [7:0] flt_crc01_off = 8'h28;
    localparam logic [7:0] flt_crc23_off = 8'h2c;

    // ------------------------------------------------------------
    // control and status field positions
    // ------------------------------------------------------------
    localparam int ctrl_pd_bit = 0;
    localparam int ctrl_magic_bit = 1;
    localparam int ctrl_filter_bit = 2;
    localparam int ctrl_unicast_bit = 9;
    localparam int stat_pd_bit = 0;
    localparam int stat_filter_bit = 5;
    localparam int stat_magic_bit = 6;
    localparam int cmd_on_bit = 0;
    localparam int cmd_group_bit = 3;

    // ------------------------------------------------------------
    // frame and checksum constants
    // ------------------------------------------------------------
    localparam int num_filters = 4;
    localparam int mask_bytes = 31;
    localparam int magic_sync_len = 6;
    localparam int magic_reps = 16;
    localparam logic [7:0] sync_byte = 8'hff;
    localparam logic [15:0] crc_poly = 16'h8005;
    localparam logic [15:0] crc_seed = 16'hffff;

    typedef struct packed {
        logic [30:0] byte_mask;
        logic on;
        logic group_sel;
        logic [7:0] start_offset;
        logic [15:0] expected;
    } filter_cfg_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic sof;
        logic eof;
    } rx_beat_t;

endpackage

// File: rtl/wake_crc_filter.sv
module wake_crc_filter
    import wake_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // setup
    input wire filter_cfg_t cfg,
    // frame stream
    input wire rx_beat_t beat,
    input wire logic [7:0] byte_idx,
    input wire logic dest_group,
    // result, one-cycle pulse on frame end
    output logic hit
);

    logic [15:0] crc_r, crc_nxt;
    logic hit_r, hit_nxt;
    logic [7:0] rel;
    logic in_win;

    // reflected form of 0x8005, data taken lsb first
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] x;
        logic [15:0] rpoly;
        x = c;
        for (int i = 0; i < 16; i++) begin
            rpoly[i] = crc_poly[15 - i];
        end
        for (int i = 0; i < 8; i++) begin
            if (x[0] ^ d[i]) begin
                x = (x >> 1) ^ rpoly;
            end else begin
                x = x >> 1;
            end
        end
        return x;
    endfunction

    always_comb begin
        rel = byte_idx - cfg.start_offset;
        in_win = (byte_idx >= cfg.start_offset) && (rel < 8'(mask_bytes));
        crc_nxt = crc_r;
        hit_nxt = 1'b0;
        if (beat.valid) begin
            if (beat.sof) begin
                crc_nxt = crc_seed;
            end
            if (in_win && cfg.byte_mask[rel[4:0]]) begin
                crc_nxt = crc_step(beat.sof ? crc_seed : crc_r, beat.data);
            end
            if (beat.eof) begin
                hit_nxt = cfg.on && (cfg.group_sel == dest_group) && (crc_nxt == cfg.expected);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc_r <= crc_seed;
            hit_r <= 1'b0;
        end else begin
            crc_r <= crc_nxt;
            hit_r <= hit_nxt;
        end
    end

    assign hit = hit_r;

endmodule

// File: rtl/wake_magic_detect.sv
module wake_magic_detect
    import wake_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // station address
    input wire logic [47:0] station,
    // frame stream
    input wire rx_beat_t beat,
    // one-cycle pulse on frame end
    output logic found
);

    // sync counts leading 0xff bytes; rep and pos walk the address copies
    logic [2:0] sync_r, sync_nxt;
    logic [4:0] rep_r, rep_nxt;
    logic [2:0] pos_r, pos_nxt;
    logic seen_r, seen_nxt;
    logic found_r, found_nxt;

    always_comb begin
        sync_nxt = sync_r;
        rep_nxt = rep_r;
        pos_nxt = pos_r;
        seen_nxt = seen_r;
        found_nxt = 1'b0;
        if (beat.valid) begin
            if (beat.sof) begin
                seen_nxt = 1'b0;
                sync_nxt = '0;
                rep_nxt = '0;
                pos_nxt = '0;
            end
            // six 0xff then sixteen address copies, back to back
            if (!seen_nxt) begin
                if (rep_nxt == 5'd0 && pos_nxt == 3'd0 && sync_nxt < 3'(magic_sync_len)) begin
                    sync_nxt = (beat.data == sync_byte) ? sync_nxt + 3'd1 : 3'd0;
                end else if (beat.data == station[8'(pos_nxt) * 8 +: 8]) begin
                    if (pos_nxt == 3'd5) begin
                        pos_nxt = 3'd0;
                        rep_nxt = rep_nxt + 5'd1;
                        if (rep_nxt == 5'(magic_reps)) begin
                            seen_nxt = 1'b1;
                        end
                    end else begin
                        pos_nxt = pos_nxt + 3'd1;
                    end
                end else begin
                    // 0xff right after a full sync keeps it; mid-address it only opens a new run
                    if (beat.data != sync_byte) begin
                        sync_nxt = 3'd0;
                    end else if (rep_nxt == 5'd0 && pos_nxt == 3'd0) begin
                        sync_nxt = 3'(magic_sync_len);
                    end else begin
                        sync_nxt = 3'd1;
                    end
                    rep_nxt = '0;
                    pos_nxt = '0;
                end
            end
            if (beat.eof) begin
                found_nxt = seen_nxt;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_r <= '0;
            rep_r <= '0;
            pos_r <= '0;
            seen_r <= 1'b0;
            found_r <= 1'b0;
        end else begin
            sync_r <= sync_nxt;
            rep_r <= rep_nxt;
            pos_r <= pos_nxt;
            seen_r <= seen_nxt;
            found_r <= found_nxt;
        end
    end

    assign found = found_r;

endmodule

// File: bench/wake_power_mgmt_assertions.sv
module wake_power_mgmt_assertions
    import wake_pkg::*;
#(
    parameter int nfilt = num_filters
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // receive path
    input wire rx_beat_t rx_in,
    input wire logic rx_addr_ok,
    input wire rx_beat_t rx_out,
    // power state
    input wire logic low_power_mode,
    input wire logic wakeup_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic acc, ctrl_w, stat_r;
    assign acc = psel && penable;
    assign ctrl_w = acc && pwrite && paddr == ctrl_off;
    assign stat_r = acc && !pwrite && paddr == status_off;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_pd_held;
        low_power_mode ##1 low_power_mode;
    endsequence
    // only from awake: a wake frame may win over the write
    sequence s_pd_enter;
        ctrl_w && pwdata[ctrl_pd_bit] && !low_power_mode;
    endsequence
    sequence s_stat_awake;
        stat_r && !low_power_mode;
    endsequence
    a_pd_enter: assert property (s_pd_enter |=> low_power_mode)
        else $error("power-down not entered on request");
    a_pd_exit: assert property (ctrl_w && !pwdata[ctrl_pd_bit] |=> !low_power_mode)
        else $error("power-down kept after clearing write");
    a_pd_drops: assert property (s_pd_held |-> !rx_out.valid)
        else $error("frame passed while powered down");
    a_rx_passes: assert property (rx_in.valid && !low_power_mode && !ctrl_w |=> rx_out == $past(rx_in))
        else $error("frame not passed while awake");
    a_pd_status: assert property (stat_r |-> prdata[stat_pd_bit] == low_power_mode)
        else $error("status power bit wrong");
    a_irq_wake: assert property ($fell(low_power_mode) && !$past(ctrl_w) |-> wakeup_irq)
        else $error("wake without irq");
    a_irq_cause: assert property ($rose(wakeup_irq) |-> $fell(low_power_mode))
        else $error("irq without wake");
    a_irq_holds: assert property (wakeup_irq && !stat_r |=> wakeup_irq)
        else $error("irq dropped without status read");
    a_irq_clears: assert property (s_stat_awake |=> !wakeup_irq)
        else $error("irq kept after status read");
    a_unmapped_err: assert property (acc && paddr > flt_crc23_off |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
endmodule
bind wake_power_mgmt wake_power_mgmt_assertions #(.nfilt(nfilt)) wake_power_mgmt_assertions_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_in(rx_in),
    .rx_addr_ok(rx_addr_ok), .rx_out(rx_out), .low_power_mode(low_power_mode), .wakeup_irq(wakeup_irq));

// File: bench/rx_frame_src.sv
module rx_frame_src
    import wake_pkg::*;
(
    // clock
    input wire logic pclk,
    // receive stream toward the block
    output rx_beat_t rx_in,
    output logic rx_addr_ok
);
    timeunit 1ns;
    timeprecision 1ns;
    rx_beat_t pend[$];
    logic okq[$];
    initial begin
        rx_in = '0;
        rx_addr_ok = 1'b0;
    end
    // idle lines toggle so that stale bytes never look like a frame
    always @(posedge pclk) begin
        if (pend.size() > 0) begin
            rx_in <= pend.pop_front();
            rx_addr_ok <= okq.pop_front();
        end else begin
            rx_in <= '{1'b0, ~rx_in.data, 1'b0, 1'b0};
            rx_addr_ok <= ~rx_addr_ok;
        end
    end
    // address verdict only means something on the last byte
    task automatic send(input logic [7:0] b[$], input logic ok);
        int i;
        @(negedge pclk);
        for (i = 0; i < b.size(); i++) begin
            pend.push_back('{1'b1, b[i], i == 0, i == b.size() - 1});
            okq.push_back(i == b.size() - 1 ? ok : ~ok);
        end
        // the last byte is launched at the last of these edges
        repeat (b.size()) @(posedge pclk);
    endtask
endmodule

// File: bench/wake_power_mgmt_tb.sv
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module wake_power_mgmt_tb
    import wake_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, er, rx_addr_ok, low_power_mode, wakeup_irq;
    rx_beat_t rx_in, rx_out;
    int n_errors = 0, n_checks = 0, n_out = 0, n0, m;
    logic [7:0] fr[$];
    logic [15:0] exp_crc;
    logic [47:0] stn = 48'h5644_3322_1102;
    logic [7:0] ra[10] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c};
    logic [31:0] rv[10] = '{32'h3322_1102, 32'h5644, 32'h1234_5678, 32'h7fff_ffff, 32'h1, 32'h4000_0000,
        32'h0801_0900, 32'h1f00_ff01, 32'hbeef_1234, 32'hcafe_f00d};
    initial begin
        forever #20 pclk = ~pclk;
    end
    wake_power_mgmt #(.nfilt(num_filters)) wake_power_mgmt_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_in(rx_in), .rx_addr_ok(rx_addr_ok), .rx_out(rx_out),
        .low_power_mode(low_power_mode), .wakeup_irq(wakeup_irq));
    rx_frame_src rx_frame_src_inst (.pclk(pclk), .rx_in(rx_in), .rx_addr_ok(rx_addr_ok));
    always @(posedge pclk) if (rx_out.valid === 1'b1) n_out <= n_out + 1;
    task final_report();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 10; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 10) begin
            n_errors++;
            final_report();
        end
        #1;
    endtask
    task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask
    task wait_lpm(input logic v, input int n);
        int i;
        for (i = 0; i < n && low_power_mode !== v; i++) begin
            @(posedge pclk);
            #1;
        end
        `CHK("power state", v, low_power_mode)
        if (low_power_mode !== v) final_report();
    endtask
    // the wake outcome shows two cycles after the last byte
    task send_chk(input logic ok, input logic lpm);
        rx_frame_src_inst.send(fr, ok);
        // look at the outcome's own cycle, so that a wrong wake is not missed
        repeat (2) @(posedge pclk);
        #1;
        wait_lpm(lpm, 0);
    endtask
    function void mk_plain(input logic [7:0] b0, input int len);
        fr.delete();
        fr.push_back(b0);
        for (int k = 1; k < len; k++) fr.push_back(8'(k * 3 + 7));
    endfunction
    function void mk_magic();
        fr.delete();
        for (int k = 0; k < 12; k++) fr.push_back(k < 6 ? stn[k * 8 +: 8] : 8'(8'h20 + k));
        for (int k = 0; k < magic_sync_len; k++) fr.push_back(sync_byte);
        for (int k = 0; k < magic_reps * 6; k++) fr.push_back(stn[(k % 6) * 8 +: 8]);
    endfunction
    // reflected form of the generator, shifted out lsb first
    function automatic logic [15:0] crc_exp(input logic [30:0] msk, input int off);
        logic [15:0] c;
        c = crc_seed;
        for (int i = 0; i < mask_bytes; i++)
            if (msk[i] && off + i < fr.size()) begin
                c = c ^ {8'h00, fr[off + i]};
                for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
            end
        return c;
    endfunction
    initial begin
        #2000000;
        n_errors++;
        final_report();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        `CHK("power state", 1'b0, low_power_mode)
        rdchk("ctrl", ctrl_off, 32'h0);
        rdchk("status", status_off, 32'h0);
        apb(1'b1, 8'h40, 32'h1);
        `CHK("unmapped write", 1'b1, er)
        rdchk("unmapped read", 8'h40, 32'h0);
        `CHK("unmapped read err", 1'b1, er)
        apb(1'b1, status_off, 32'h61);
        rdchk("status write", status_off, 32'h0);
        $display("test reset and map done");
        foreach (ra[i]) apb(1'b1, ra[i], rv[i]);
        foreach (ra[i]) rdchk("filter setup", ra[i], rv[i]);
        $display("test readback done");
        // ----------------------------------------
        // power-down and magic frame
        // ----------------------------------------
        apb(1'b1, ctrl_off, 32'h3);
        rdchk("ctrl", ctrl_off, 32'h3);
        rdchk("status", status_off, 32'h1);
        n0 = n_out;
        mk_plain(8'h02, 20);
        send_chk(1'b1, 1'b1);
        mk_magic();
        fr[14] = 8'h00;
        send_chk(1'b1, 1'b1);
        `CHK("dropped beats", n0, n_out)
        mk_magic();
        send_chk(1'b1, 1'b0);
        `CHK("irq", 1'b1, wakeup_irq)
        rdchk("status", status_off, 32'h40);
        `CHK("irq", 1'b0, wakeup_irq)
        rdchk("status", status_off, 32'h0);
        n0 = n_out;
        mk_plain(8'h02, 12);
        rx_frame_src_inst.send(fr, 1'b1);
        repeat (3) @(posedge pclk);
        `CHK("passed beats", n0 + 12, n_out)
        $display("test magic wake done");
        // ----------------------------------------
        // filter wake
        // ----------------------------------------
        mk_plain(8'h02, 40);
        exp_crc = crc_exp(31'h15, 14);
        apb(1'b1, flt_mask_base, 32'h15);
        apb(1'b1, flt_offset_off, 32'he);
        apb(1'b1, flt_crc01_off, {16'h0, exp_crc ^ 16'h1});
        apb(1'b1, flt_cmd_off, 32'h1);
        apb(1'b1, ctrl_off, 32'h5);
        send_chk(1'b1, 1'b1);
        apb(1'b1, flt_crc01_off, {16'h0, exp_crc});
        apb(1'b1, flt_cmd_off, 32'h0);
        send_chk(1'b1, 1'b1);
        for (m = 0; m < 2; m++) begin
            apb(1'b1, flt_cmd_off, m ? 32'h9 : 32'h1);
            apb(1'b1, ctrl_off, 32'h5);
            mk_plain(m ? 8'h02 : 8'h03, 40);
            send_chk(1'b1, 1'b1);
            fr[0] = m ? 8'h03 : 8'h02;
            send_chk(1'b1, 1'b0);
            rdchk("status", status_off, 32'h20);
            rdchk("status", status_off, 32'h0);
        end
        $display("test filter wake done");
        // ----------------------------------------
        // unicast wake and software exit
        // ----------------------------------------
        apb(1'b1, flt_cmd_off, 32'h0);
        apb(1'b1, ctrl_off, 32'h201);
        mk_plain(8'h02, 10);
        send_chk(1'b0, 1'b1);
        send_chk(1'b1, 1'b0);
        `CHK("irq", 1'b1, wakeup_irq)
        rdchk("status", status_off, 32'h0);
        `CHK("irq", 1'b0, wakeup_irq)
        apb(1'b1, ctrl_off, 32'h3);
        `CHK("power state", 1'b1, low_power_mode)
        apb(1'b1, ctrl_off, 32'h2);
        `CHK("power state", 1'b0, low_power_mode)
        `CHK("irq", 1'b0, wakeup_irq)
        $display("test unicast and exit done");
        final_report();
    end
endmodule
